// ===== src/mtrl_defines.svh
// Offsets, field positions, reset values and encodings of the memory type range lookup
`ifndef MTRL_DEFINES_SVH
`define MTRL_DEFINES_SVH

// Register index map, one 64-bit register per index
`define MTRL_IDX_W 6
`define MTRL_FIX_CNT 6'd11
`define MTRL_VAR_CNT 8
`define MTRL_VAR_GROUP 2'b01
`define MTRL_IDX_DEF 6'h20

// Fixed register numbers of the 16K and 4K groups
`define MTRL_FIX16_REG 4'h1
`define MTRL_FIX4_REG 4'h3

// Physical address layout
`define MTRL_PA_W 52
`define MTRL_RNG_W 40
`define MTRL_MEG_BIT 20

// Field positions
`define MTRL_VALID_BIT 11
`define MTRL_FE_BIT 10
`define MTRL_GE_BIT 11

// Writable bits of each register kind
`define MTRL_FIX_MASK 64'h1F1F1F1F1F1F1F1F
`define MTRL_BASE_MASK 64'h000FFFFFFFFFF007
`define MTRL_RMASK_MASK 64'h000FFFFFFFFFF800
`define MTRL_DEF_MASK 64'h0000000000000C07

// Memory type encodings
`define MTRL_TYPE_UC 3'h0
`define MTRL_TYPE_WC 3'h1
`define MTRL_TYPE_WT 3'h4
`define MTRL_TYPE_WP 3'h5
`define MTRL_TYPE_WB 3'h6

// Reset values
`define MTRL_RST_WORD 64'h0000000000000000
`define MTRL_RST_TYPE 3'h0

`endif

// ===== src/mtrl_pkg.sv
// Types shared by the memory type range lookup files
`default_nettype none
package mtrl_pkg;
  typedef logic [2:0] mtrl_mtype_t;
  typedef struct packed {
    logic readToMemBit;
    logic writeToMemBit;
    mtrl_mtype_t memType;
  } mtrl_result_t;
  typedef struct packed {
    logic [3:0] regNum;
    logic [2:0] lane;
  } mtrl_slot_t;
endpackage : mtrl_pkg
`default_nettype wire

// ===== src/mtrl_fixed_mem.sv
// Storage of the eleven fixed-range type registers, two registered read ports
`timescale 1ns/10ps
`default_nettype none
`include "mtrl_defines.svh"
module mtrl_fixed_mem
  import mtrl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write port
  input wire logic wrEn,
  input wire logic [3:0] wrIdx,
  input wire logic [63:0] wrData,
  // Register read port
  input wire logic [3:0] rdIdxA,
  output var logic [63:0] rdDataA,
  // Lookup read port
  input wire logic [3:0] rdIdxB,
  output var logic [63:0] rdDataB
);
  logic [63:0] word_q [11];

  // Words clear to uncacheable so a fresh part has a defined map
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 11; i++)
        word_q[i] <= `MTRL_RST_WORD;
    end
    else if (wrEn && wrIdx < `MTRL_FIX_CNT)
      word_q[wrIdx] <= wrData;
  end

  // Read data leave through registers; out of range reads give zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdDataA <= `MTRL_RST_WORD;
      rdDataB <= `MTRL_RST_WORD;
    end
    else
    begin
      rdDataA <= (rdIdxA < `MTRL_FIX_CNT) ? word_q[rdIdxA] : `MTRL_RST_WORD;
      rdDataB <= (rdIdxB < `MTRL_FIX_CNT) ? word_q[rdIdxB] : `MTRL_RST_WORD;
    end
  end
endmodule : mtrl_fixed_mem
`default_nettype wire

// ===== src/mtrl_lookup.sv
// Memory type range registers and the per-address memory type lookup
`timescale 1ns/10ps
`default_nettype none
`include "mtrl_defines.svh"

// Overview of operation
// R1 - Fixed ranges apply below one megabyte only; variable ranges anywhere
// R2 - Addresses covered by no enabled range get the default type field
// R3 - Every range register is 64 bits, read and written by register instructions
// R4 - Fixed register holds eight byte-wide type fields, one per lane
// R5 - One fixed register types lowest 512K in eight 64K pieces
// R6 - Two fixed registers type 80000-BFFFF in sixteen 16K pieces
// R7 - Eight fixed registers type C0000-FFFFF in sixty-four 4K pieces
// R8 - Lowest byte types lowest sub-range, higher bytes the following ones
// R9 - Fixed fields accept extended encoding with read and write memory bits
// R10 - Eight variable ranges, each a base and mask register pair
// R11 - Variable base type in bits 7:0, standard encodings only
// R12 - Variable base holds address bits 51:12; low bits read as zero
// R13 - Mask bit 11 enables the pair; clear means it never matches
// R14 - Mask register holds 40-bit mask in bits 51:12
// R15 - Match when mask AND base equals mask AND address bits 51:12
// R16 - Software sizes ranges as aligned powers of two, at least 4K
// R17 - Software forms mask from memory size minus range span, dropping 12 bits
// R18 - Default register holds default type in bits 7:0, standard only
// R19 - Default bit 10 enables fixed ranges, honoured only with global enable; here the fixed memory control bits need bit 10 alone
// R20 - Default bit 11 clear makes every address uncacheable
// R21 - All fields of base, mask and default registers are read/write
// R22 - Types: UC 00h, WC 01h, WT 04h, WP 05h, WB 06h
// R23 - Extended encoding uses bits 4:3 for memory controls, 7:5 reserved
// R24 - Enabled fixed range beats a variable range below one megabyte
// R25 - Variable overlaps: same type, UC wins, WT over WB, else undefined
// R26 - Every core address is looked up; writes apply from next access
module mtrl_lookup
  import mtrl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Model specific register access
  input wire logic regRdEn,
  input wire logic regWrEn,
  input wire logic [5:0] regIdx,
  input wire logic [63:0] regWrData,
  output var logic regRdValid_q,
  output var logic [63:0] regRdData_q,
  // Core address lookup
  input wire logic reqValid,
  input wire logic [51:0] reqAddr,
  output var logic resValid_q,
  output var mtrl_result_t res_q
);

  // Variable pairs and default control
  logic [39:0] baseAddr_q [8];
  mtrl_mtype_t baseType_q [8];
  logic [39:0] maskAddr_q [8];
  logic [7:0] maskValid_q;
  mtrl_mtype_t defType_q;
  logic fixedEn_q;
  logic globalEn_q;

  // Read pipeline
  logic rdPend_q;
  logic rdFix_q;
  logic [63:0] rdOther_q;
  logic [63:0] otherRd;
  logic [63:0] fixRdA;

  // Lookup pipeline
  mtrl_slot_t slot;
  logic below;
  logic [7:0] hit;
  logic [7:0] seen;
  logic s1Valid_q;
  logic s1Below_q;
  logic [2:0] s1Lane_q;
  logic [7:0] s1Hit_q;
  logic [7:0] s1Seen_q;
  mtrl_mtype_t s1VarType_q;
  logic [63:0] fixRdB;
  logic [7:0] fixField;
  mtrl_result_t resD;

  logic varSel;
  logic [2:0] varNum;
  logic fixWr;

  // Maps a sub-megabyte address to its fixed register and byte lane [R5] [R6] [R7] [R8]
  function automatic mtrl_slot_t fixSlot(input logic [19:0] a);
    mtrl_slot_t s;
    if (!a[19])
    begin
      s.regNum = 4'h0;
      s.lane = a[18:16];
    end
    else if (!a[18])
    begin
      s.regNum = `MTRL_FIX16_REG + {3'h0, a[17]};
      s.lane = a[16:14];
    end
    else
    begin
      s.regNum = `MTRL_FIX4_REG + {1'b0, a[17:15]};
      s.lane = a[14:12];
    end
    return s;
  endfunction : fixSlot

  // Bits a write may set at each index; the rest read as zero
  function automatic logic [63:0] wrMask(input logic [5:0] idx);
    logic [63:0] m;
    m = `MTRL_RST_WORD;
    if (idx < `MTRL_FIX_CNT)
      m = `MTRL_FIX_MASK;
    else if (idx[5:4] == `MTRL_VAR_GROUP)
      m = idx[0] ? `MTRL_RMASK_MASK : `MTRL_BASE_MASK;
    else if (idx == `MTRL_IDX_DEF)
      m = `MTRL_DEF_MASK;
    return m;
  endfunction : wrMask

  // Merges the types of all matching variable ranges
  function automatic mtrl_mtype_t varResolve(input logic [7:0] s);
    mtrl_mtype_t t;
    t = `MTRL_TYPE_UC;
    if (s[`MTRL_TYPE_UC])
      t = `MTRL_TYPE_UC; // [R25]
    else if ($countones(s) == 1)
    begin
      for (int i = 0; i < 8; i++)
        if (s[i])
          t = 3'(i);
    end
    else if (s == ((8'h1 << `MTRL_TYPE_WT) | (8'h1 << `MTRL_TYPE_WB)))
      t = `MTRL_TYPE_WT; // [R25]
    // Undefined mixes fall back to uncacheable, the safest choice
    return t;
  endfunction : varResolve

  // Write decode; unmapped indices are ignored
  assign varSel = (regIdx[5:4] == `MTRL_VAR_GROUP);
  assign varNum = regIdx[3:1];
  assign fixWr = regWrEn && (regIdx < `MTRL_FIX_CNT);

  // Fixed words keep only type and memory control bits [R3] [R4] [R9] [R23]
  mtrl_fixed_mem u_fixMem (
    .clk(clk),
    .rst(rst),
    .wrEn(fixWr),
    .wrIdx(regIdx[3:0]),
    .wrData(regWrData & `MTRL_FIX_MASK),
    .rdIdxA(regIdx[3:0]),
    .rdDataA(fixRdA),
    .rdIdxB(slot.regNum),
    .rdDataB(fixRdB)
  );

  // Variable pairs: standard type, address fields, valid bit [R10] [R11] [R12] [R13] [R14] [R21]
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int n = 0; n < `MTRL_VAR_CNT; n++)
      begin
        baseAddr_q[n] <= '0;
        baseType_q[n] <= `MTRL_RST_TYPE;
        maskAddr_q[n] <= '0;
      end
      maskValid_q <= 8'h00;
    end
    else if (regWrEn && varSel)
    begin
      if (!regIdx[0])
      begin
        baseAddr_q[varNum] <= regWrData[51:12];
        baseType_q[varNum] <= regWrData[2:0];
      end
      else
      begin
        maskAddr_q[varNum] <= regWrData[51:12];
        maskValid_q[varNum] <= regWrData[`MTRL_VALID_BIT];
      end
    end
  end

  // Default type and the two enables; typing is off after reset [R18] [R19] [R20] [R21]
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      defType_q <= `MTRL_RST_TYPE;
      fixedEn_q <= 1'b0;
      globalEn_q <= 1'b0;
    end
    else if (regWrEn && regIdx == `MTRL_IDX_DEF)
    begin
      defType_q <= regWrData[2:0];
      fixedEn_q <= regWrData[`MTRL_FE_BIT];
      globalEn_q <= regWrData[`MTRL_GE_BIT];
    end
  end

  // Read back of the registers held here
  always_comb
  begin
    otherRd = `MTRL_RST_WORD;
    if (varSel)
    begin
      if (!regIdx[0])
        otherRd = {12'h000, baseAddr_q[varNum], 9'h000, baseType_q[varNum]};
      else
        otherRd = {12'h000, maskAddr_q[varNum], maskValid_q[varNum], 11'h000};
    end
    else if (regIdx == `MTRL_IDX_DEF)
      otherRd = {52'h0, globalEn_q, fixedEn_q, 7'h00, defType_q};
  end

  // Reads take two cycles so fixed words come out of the memory register [R3]
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdPend_q <= 1'b0;
      rdFix_q <= 1'b0;
      rdOther_q <= `MTRL_RST_WORD;
      regRdValid_q <= 1'b0;
      regRdData_q <= `MTRL_RST_WORD;
    end
    else
    begin
      rdPend_q <= regRdEn;
      rdFix_q <= regIdx < `MTRL_FIX_CNT;
      rdOther_q <= otherRd;
      regRdValid_q <= rdPend_q;
      regRdData_q <= rdPend_q ? (rdFix_q ? fixRdA : rdOther_q) : `MTRL_RST_WORD;
    end
  end

  // Variable range matching over address bits 51:12
  always_comb
  begin
    slot = fixSlot(reqAddr[19:0]);
    below = (reqAddr[51:`MTRL_MEG_BIT] == 32'h0); // [R1]
    hit = 8'h00;
    seen = 8'h00;
    for (int n = 0; n < `MTRL_VAR_CNT; n++)
    begin
      if (maskValid_q[n] && ((maskAddr_q[n] & baseAddr_q[n]) == (maskAddr_q[n] & reqAddr[51:12]))) // [R13] [R15]
      begin
        hit[n] = 1'b1;
        seen[baseType_q[n]] = 1'b1;
      end
    end
  end

  // First stage: fixed word fetched while variable result is merged [R26]
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1Valid_q <= 1'b0;
      s1Below_q <= 1'b0;
      s1Lane_q <= 3'h0;
      s1Hit_q <= 8'h00;
      s1Seen_q <= 8'h00;
      s1VarType_q <= `MTRL_RST_TYPE;
    end
    else
    begin
      s1Valid_q <= reqValid;
      s1Below_q <= below;
      s1Lane_q <= slot.lane;
      s1Hit_q <= hit;
      s1Seen_q <= seen;
      s1VarType_q <= varResolve(seen); // [R25]
    end
  end

  // Final priority: global enable, then fixed, then variable, then default
  always_comb
  begin
    fixField = fixRdB[{s1Lane_q, 3'h0} +: 8]; // [R4] [R8]
    resD.readToMemBit = 1'b0;
    resD.writeToMemBit = 1'b0;
    // Memory control bits follow the fixed field even with typing off
    if (s1Below_q && fixedEn_q)
    begin
      resD.readToMemBit = fixField[4]; // [R9] [R23]
      resD.writeToMemBit = fixField[3];
    end
    if (!globalEn_q)
      resD.memType = `MTRL_TYPE_UC; // [R20]
    else if (s1Below_q && fixedEn_q)
      resD.memType = fixField[2:0]; // [R19] [R24] [R22]
    else if (s1Hit_q != 8'h00)
      resD.memType = s1VarType_q; // [R25]
    else
      resD.memType = defType_q; // [R2]
  end

  // Second stage: result register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      resValid_q <= 1'b0;
      res_q <= '0;
    end
    else
    begin
      resValid_q <= s1Valid_q;
      res_q <= resD;
    end
  end

  // Checks on lookup and register behaviour
  property p_latency;
    @(posedge clk) disable iff (rst)
    reqValid |-> ##2 resValid_q;
  endproperty
  a_latency: assert property (p_latency) else $error("lookup answer not two cycles later"); // [R26]

  property p_global_off;
    @(posedge clk) disable iff (rst)
    resValid_q && !$past(globalEn_q) |-> res_q.memType == `MTRL_TYPE_UC;
  endproperty
  a_global_off: assert property (p_global_off) else $error("disabled typing not uncacheable"); // [R20]

  property p_fixed_wins;
    @(posedge clk) disable iff (rst)
    resValid_q && $past(globalEn_q) && $past(fixedEn_q) && $past(s1Below_q)
      |-> res_q.memType == $past(fixField[2:0]);
  endproperty
  a_fixed_wins: assert property (p_fixed_wins) else $error("fixed type not used"); // [R24]

  property p_default;
    @(posedge clk) disable iff (rst)
    resValid_q && $past(globalEn_q) && !($past(fixedEn_q) && $past(s1Below_q)) && $past(s1Hit_q) == 8'h00
      |-> res_q.memType == $past(defType_q);
  endproperty
  a_default: assert property (p_default) else $error("unmapped address not default type"); // [R2]

  property p_uc_wins;
    @(posedge clk) disable iff (rst)
    resValid_q && $past(globalEn_q) && !($past(fixedEn_q) && $past(s1Below_q)) && $past(s1Seen_q[0])
      |-> res_q.memType == `MTRL_TYPE_UC;
  endproperty
  a_uc_wins: assert property (p_uc_wins) else $error("overlap with uncacheable not uncacheable"); // [R25]

  property p_above_meg;
    @(posedge clk) disable iff (rst)
    reqValid && reqAddr[51:`MTRL_MEG_BIT] != 32'h0
      |=> !s1Below_q ##1 !res_q.readToMemBit && !res_q.writeToMemBit;
  endproperty
  a_above_meg: assert property (p_above_meg) else $error("fixed range used above one megabyte"); // [R1]

  property p_invalid_pair;
    @(posedge clk) disable iff (rst)
    reqValid && !maskValid_q[0] |=> !s1Hit_q[0];
  endproperty
  a_invalid_pair: assert property (p_invalid_pair) else $error("disabled pair matched"); // [R13]

  property p_base_match;
    @(posedge clk) disable iff (rst)
    reqValid && maskValid_q[1] && reqAddr[51:12] == baseAddr_q[1] |=> s1Hit_q[1];
  endproperty
  a_base_match: assert property (p_base_match) else $error("base address did not match its range"); // [R15]

  property p_mem_bits;
    @(posedge clk) disable iff (rst)
    resValid_q && $past(s1Below_q) && $past(fixedEn_q)
      |-> {res_q.readToMemBit, res_q.writeToMemBit} == $past(fixField[4:3]);
  endproperty
  a_mem_bits: assert property (p_mem_bits) else $error("memory control bits lost"); // [R23]

  property p_readback;
    @(posedge clk) disable iff (rst)
    regWrEn && !regRdEn ##1 regRdEn && !regWrEn && regIdx == $past(regIdx)
      |-> ##2 regRdValid_q && regRdData_q == ($past(regWrData, 3) & wrMask($past(regIdx, 3)));
  endproperty
  a_readback: assert property (p_readback) else $error("register read back differs"); // [R21]

  c_fixed_hit: cover property (@(posedge clk) disable iff (rst)
    s1Valid_q && globalEn_q && fixedEn_q && s1Below_q);
  c_var_hit: cover property (@(posedge clk) disable iff (rst)
    s1Valid_q && globalEn_q && !s1Below_q && s1Hit_q != 8'h00);
  c_wt_wb: cover property (@(posedge clk) disable iff (rst)
    s1Valid_q && s1Seen_q == ((8'h1 << `MTRL_TYPE_WT) | (8'h1 << `MTRL_TYPE_WB)));
  c_readback: cover property (@(posedge clk) disable iff (rst)
    regRdValid_q && regRdData_q != `MTRL_RST_WORD);
endmodule : mtrl_lookup
`default_nettype wire

// ===== test/mtrl_core_model.sv
// Core-side partner: presents lookup addresses and counts returned results
`timescale 1ns/10ps
`default_nettype none
module mtrl_core_model
  import mtrl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Lookup orders from the bench
  input wire logic lkValid,
  input wire logic [51:0] lkAddr,
  // Lookup port of the block
  output var logic reqValid,
  output var logic [51:0] reqAddr,
  input wire logic resValid_q,
  input wire mtrl_result_t res_q,
  // Results seen
  output var logic [15:0] resCnt_q
);
  logic [51:0] heldAddr_q;
  // Idle address shows the inverted last one, so no result can ride on a stale address
  always_ff @(posedge clk)
  begin
    if (rst)
      heldAddr_q <= '0;
    else if (lkValid)
      heldAddr_q <= lkAddr;
  end
  assign reqValid = lkValid;
  assign reqAddr = lkValid ? lkAddr : ~heldAddr_q;
  // Every presented address must come back as one result
  always_ff @(posedge clk)
  begin
    if (rst)
      resCnt_q <= '0;
    else if (resValid_q)
      resCnt_q <= resCnt_q + 16'h1;
  end
endmodule : mtrl_core_model
`default_nettype wire

// ===== test/mtrl_lookup_tb.sv
// Self-checking bench of the memory type range lookup
`timescale 1ns/10ps
`default_nettype none
`include "mtrl_defines.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module mtrl_lookup_tb
  import mtrl_pkg::*;
;
  // Stimulus and observed signals
  logic clk, rst, regRdEn, regWrEn, lkValid, reqValid, regRdValid_q, resValid_q;
  logic [5:0] regIdx;
  logic [63:0] regWrData, regRdData_q;
  logic [51:0] lkAddr, reqAddr;
  logic [15:0] resCnt;
  mtrl_result_t res_q;
  int error_cnt = 0, n_checks = 0, nLook = 0, cycles = 0;
  mtrl_mtype_t tList [5] = '{`MTRL_TYPE_UC, `MTRL_TYPE_WC, `MTRL_TYPE_WT, `MTRL_TYPE_WP, `MTRL_TYPE_WB};
  mtrl_result_t wbRes = '{1'b0, 1'b0, `MTRL_TYPE_WB};
  mtrl_result_t ucRes = '{1'b0, 1'b0, `MTRL_TYPE_UC};

  mtrl_lookup u_mtrl_lookup (.clk(clk), .rst(rst), .regRdEn(regRdEn), .regWrEn(regWrEn), .regIdx(regIdx),
    .regWrData(regWrData), .regRdValid_q(regRdValid_q), .regRdData_q(regRdData_q), .reqValid(reqValid),
    .reqAddr(reqAddr), .resValid_q(resValid_q), .res_q(res_q));
  mtrl_core_model u_mtrl_core_model (.clk(clk), .rst(rst), .lkValid(lkValid), .lkAddr(lkAddr),
    .reqValid(reqValid), .reqAddr(reqAddr), .resValid_q(resValid_q), .res_q(res_q), .resCnt_q(resCnt));

  // 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Inputs move 1 ns after the edge, clear of sampling
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  // Strobe stays up across back-to-back writes; the next read or lookup lowers it
  task automatic regWr(input logic [5:0] idx, input logic [63:0] d);
    regWrEn = 1'b1;
    regIdx = idx;
    regWrData = d;
    step();
  endtask : regWr

  // Read data stand from the second edge after the request and are sampled 1 ns after it
  task automatic regRd(input logic [5:0] idx, input logic [63:0] e);
    regWrEn = 1'b0;
    regRdEn = 1'b1;
    regIdx = idx;
    step();
    regRdEn = 1'b0;
    step();
    `CHK(regRdValid_q, 1'b1)
    `CHK(regRdData_q, e)
  endtask : regRd

  // Result stands for one cycle only, so it is looked at right after it appears
  task automatic look(input logic [51:0] a, input mtrl_result_t e);
    regWrEn = 1'b0;
    lkValid = 1'b1;
    lkAddr = a;
    step();
    lkValid = 1'b0;
    nLook++;
    step();
    `CHK(resValid_q, 1'b1)
    `CHK(res_q, e)
  endtask : look

  // Mask is formed as software must: aligned power-of-two size, low 12 bits dropped
  task automatic setVar(input int n, input logic [51:0] b, input int sz, input mtrl_mtype_t t, input logic v);
    regWr(6'(16 + 2 * n), {12'h0, b} | 64'(t));
    regWr(6'(17 + 2 * n), (~((64'h1 << sz) - 1) & 64'h000F_FFFF_FFFF_F000) | (64'(v) << 11));
  endtask : setVar

  function automatic int subExp(input int r);
    return r == 0 ? 16 : r < 3 ? 14 : 12;
  endfunction : subExp

  function automatic logic [51:0] subBase(input int r, input int j);
    if (r == 0)
      return 52'(j) << 16;
    if (r < 3)
      return 52'h80000 + (52'(r - 1) << 17) + (52'(j) << 14);
    return 52'hC0000 + (52'(r - 3) << 15) + (52'(j) << 12);
  endfunction : subBase

  function automatic mtrl_result_t fixRes(input int r, input int j);
    return '{j[0], j[1], tList[(r + j) % 5]};
  endfunction : fixRes

  // Reset values, writable bits and two unmapped indices
  task automatic t_regs;
    logic [5:0] idx [7] = '{6'h00, 6'h0A, 6'h10, 6'h1F, 6'h20, 6'h21, 6'h3F};
    logic [63:0] wm [7] = '{`MTRL_FIX_MASK, `MTRL_FIX_MASK, `MTRL_BASE_MASK, `MTRL_RMASK_MASK, `MTRL_DEF_MASK,
      64'h0, 64'h0};
    look(52'hC0000, ucRes);
    for (int i = 0; i < 7; i++)
    begin
      regRd(idx[i], 64'h0);
      regWr(idx[i], '1);
      regRd(idx[i], wm[i]);
      regWr(idx[i], 64'h0);
    end
    $display("test t_regs done");
  endtask : t_regs

  // Every fixed sub-range at both ends, under three enable settings
  task automatic t_fixed;
    logic [63:0] w;
    mtrl_result_t e;
    setVar(0, 52'h0, 20, `MTRL_TYPE_WC, 1'b1);
    for (int r = 0; r < 11; r++)
    begin
      w = '0;
      for (int j = 0; j < 8; j++)
        w[j * 8 +: 8] = {3'h0, fixRes(r, j)};
      regWr(6'(r), w);
    end
    for (int m = 0; m < 3; m++)
    begin
      regWr(`MTRL_IDX_DEF, m == 0 ? 64'hC06 : m == 1 ? 64'h806 : 64'h406);
      for (int r = 0; r < 11; r++)
        for (int j = 0; j < 8; j++)
          for (int k = 0; k < 2; k++)
          begin
            e = fixRes(r, j);
            if (m == 1)
              e = '{1'b0, 1'b0, `MTRL_TYPE_WC};
            if (m == 2)
              e.memType = `MTRL_TYPE_UC;
            look(subBase(r, j) + (k == 1 ? (52'h1 << subExp(r)) - 1 : 52'h0), e);
          end
      look(52'h100000, m == 2 ? ucRes : wbRes);
    end
    $display("test t_fixed done");
  endtask : t_fixed

  // Each variable pair alone, then overlapping pairs
  task automatic t_var;
    logic [51:0] b;
    int ovA [4] = '{2, 4, 1, 3};
    int ovB [4] = '{4, 0, 1, 4};
    int ovE [4] = '{2, 0, 1, 0};
    setVar(0, 52'h0, 20, `MTRL_TYPE_WC, 1'b0);
    regWr(`MTRL_IDX_DEF, 64'h806);
    for (int n = 0; n < 8; n++)
    begin
      b = 52'h1 << (20 + 4 * n);
      setVar(n, b, 12 + n, tList[n % 5], 1'b1);
      look(b, '{1'b0, 1'b0, tList[n % 5]});
      look(b + (52'h1 << (12 + n)) - 1, '{1'b0, 1'b0, tList[n % 5]});
      look(b + (52'h1 << (12 + n)), wbRes);
      look(b - 1, wbRes);
      setVar(n, b, 12 + n, tList[n % 5], 1'b0);
      look(b, wbRes);
    end
    for (int p = 0; p < 4; p++)
    begin
      setVar(2, 52'h4000_0000, 24, tList[ovA[p]], 1'b1);
      setVar(5, 52'h4000_0000, 12, tList[ovB[p]], 1'b1);
      look(52'h4000_0000, '{1'b0, 1'b0, tList[ovE[p]]});
      look(52'h4000_1000, '{1'b0, 1'b0, tList[ovA[p]]});
    end
    $display("test t_var done");
  endtask : t_var

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // Hang guard, well above the roughly 1300 cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    regRdEn = 1'b0;
    regWrEn = 1'b0;
    regIdx = '0;
    regWrData = '0;
    lkValid = 1'b0;
    lkAddr = '0;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_regs();
    t_fixed();
    t_var();
    step();
    `CHK(resCnt, 16'(nLook))
    print_verdict();
  end
endmodule : mtrl_lookup_tb
`default_nettype wire
